// File: src/genset_cc.sv
// crank-cut, coolant relay, fuel gating, service and engine-link control
// How it works
// R01: gas solenoid opens once crank_sec reaches the gas delay while cranking; the first crank cycle compares the crank_sec left from before the start.
// R02: crank drops when phase-one voltage reaches the cut voltage.
// R03: crank drops when alternator frequency reaches the cut frequency.
// R04: crank drops when engine speed reaches the cut speed.
// R05: crank drops when charge-alternator voltage reaches the cut charge voltage.
// R06: a setting bit enables the charge-voltage cut, off by default.
// R07: a setting bit enables cutting on oil switch open or high pressure.
// R08: the oil condition must hold for the oil delay before it cuts.
// R09: zero tank capacity hides the fuel quantity.
// R10: hourly percentage thresholds theft and fuelling messages; zero disables both.
// R11: cooler turns on above the cooler-on temperature.
// R12: cooler turns off below the cooler-off temperature, giving hysteresis.
// R13: heater turns on below the heater-on temperature.
// R14: heater turns off above the heater-off temperature.
// R15: cooler stays on for the fan overrun time after dropping below off.
// R16: each channel requests service when hours reach its hour limit.
// R17: each channel requests service when months reach its period.
// R18: a zero hour limit or zero period disables that request.
// R19: each channel's two-bit level picks none, shutdown, load dump or warning.
// R20: with the engine link off, the link port stays inoperative.
// R21: with the engine link on, oil, temperature and speed come from the ECU.
// R22: with the engine link on, losing the ECU stops the engine.
// R23: the crank timer bounds each attempt, which ends early when the engine fires.
// R24: every enabled cut condition acts alone; the first true one cuts.
// R25: all delays count whole seconds from a one-second tick.
`timescale 1ns/10ps
`default_nettype none
module genset_cc #(
   parameter int unsigned TICK_CYCLES = genset_cc_pkg::TICK_CYC
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RESETN_I,
   // avalon-mm slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // alternator and engine measurements
   input wire logic [15:0] GEN_VOLT_I,
   input wire logic [7:0] GEN_FREQ_I,
   input wire logic [7:0] CHG_VOLT_I,
   input wire logic [15:0] RPM_I,
   input wire logic [7:0] COOLANT_I,
   input wire logic [7:0] OIL_PRES_I,
   input wire logic OIL_SW_OPEN_I,
   // engine control unit values
   input wire logic [15:0] ECU_RPM_I,
   input wire logic [7:0] ECU_COOLANT_I,
   input wire logic [7:0] ECU_OIL_PRES_I,
   input wire logic ECU_LOST_I,
   // fuel and service counters
   input wire logic [7:0] FUEL_DROP_PCT_I,
   input wire logic [7:0] FUEL_RISE_PCT_I,
   input wire logic [2:0][15:0] SVC_HOURS_I,
   input wire logic [2:0][7:0] SVC_MONTHS_I,
   // relay functions and indicators
   output logic CRANK_O,
   output logic GAS_SOL_O,
   output logic COOLER_O,
   output logic HEATER_O,
   output logic SVC_LED_O,
   output logic SHUTDOWN_O,
   output logic LOADDUMP_O,
   output logic WARNING_O,
   output logic FUEL_SHOW_O,
   output logic THEFT_MSG_O,
   output logic FUELLING_MSG_O,
   output logic ECU_PORT_EN_O,
   output logic ENG_STOP_O,
   output logic CRANK_FAIL_O
);
   // ==========================================================
   // types
   typedef enum logic [1:0] {C_IDLE, C_CRANK, C_RUN, C_FAIL} crank_st_t;
   typedef struct packed {
      crank_st_t st;
      logic ack;
      logic wreq;
      logic [31:0] rdata;
      logic [31:0] ctrl;
      logic [31:0] cut_v;
      logic [31:0] cut_hz;
      logic [31:0] cut_rpm;
      logic [31:0] cut_chg;
      logic [31:0] times;
      logic [31:0] cool;
      logic [31:0] fuel;
      logic [2:0][31:0] svc;
      logic [7:0] crank_sec;
      logic [7:0] oil_sec;
      logic [7:0] fan_sec;
      logic crank;
      logic gas;
      logic cooler;
      logic heater;
      logic [2:0] req;
      logic led;
      logic shut;
      logic dump;
      logic warn;
      logic fuel_show;
      logic theft;
      logic fuelling;
      logic ecu_port;
      logic stop;
      logic fail;
   } state_t;

   state_t s;
   state_t next_s;
   logic tick;

   // ==========================================================
   // seconds tick
   sec_tick #(.CYCLES(TICK_CYCLES)) u_tick (
      .clk_i(MCLK_I),
      .rstn_i(RESETN_I),
      .tick_o(tick)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic lvl_is(input logic [2:0] req, input logic [2:0][31:0] svc,
                                   input logic [1:0] lvl);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 3; i++) begin
         hit = hit | (req[i] & (svc[i][genset_cc_pkg::SV_LEVEL +: 2] == lvl));
      end
      return hit;
   endfunction

   // ==========================================================
   // measurement selection and comparisons
   logic ecu_en;
   logic [15:0] rpm;
   logic [7:0] temp;
   logic [7:0] oil_p;
   logic cut_volt;
   logic cut_freq;
   logic cut_spd;
   logic cut_chg;
   logic oil_cond;
   logic cut_oil;
   logic cut_any;
   logic [2:0] req_now;

   assign ecu_en = s.ctrl[genset_cc_pkg::CTRL_ECU_EN];
   assign rpm = ecu_en ? ECU_RPM_I : RPM_I; // R21
   assign temp = ecu_en ? ECU_COOLANT_I : COOLANT_I; // R21
   assign oil_p = ecu_en ? ECU_OIL_PRES_I : OIL_PRES_I; // R21
   assign cut_volt = GEN_VOLT_I >= s.cut_v[15:0]; // R02
   assign cut_freq = GEN_FREQ_I >= s.cut_hz[7:0]; // R03
   assign cut_spd = rpm >= s.cut_rpm[15:0]; // R04
   assign cut_chg = s.ctrl[genset_cc_pkg::CTRL_CHG_EN] & (CHG_VOLT_I >= s.cut_chg[7:0]); // R05 R06
   // the switch is ignored under the engine link: pressure then comes from the ECU
   assign oil_cond = s.ctrl[genset_cc_pkg::CTRL_OIL_EN] &
                     ((OIL_SW_OPEN_I & ~ecu_en) |
                      (oil_p > s.ctrl[genset_cc_pkg::CTRL_OIL_LIM +: 8])); // R07
   assign cut_oil = oil_cond & (s.oil_sec >= s.times[genset_cc_pkg::TM_OIL +: 8]); // R08
   assign cut_any = cut_volt | cut_freq | cut_spd | cut_chg | cut_oil; // R24

   // ==========================================================
   // service channels
   for (genvar g = 0; g < 3; g++) begin : g_svc
      logic [15:0] hlim;
      logic [7:0] mlim;
      assign hlim = {3'h0, s.svc[g][genset_cc_pkg::SV_HOURS +: 13]};
      assign mlim = {3'h0, s.svc[g][genset_cc_pkg::SV_MONTHS +: 5]};
      assign req_now[g] = ((hlim != 16'h0000) & (SVC_HOURS_I[g] >= hlim)) | // R16 R18
                          ((mlim != 8'h00) & (SVC_MONTHS_I[g] >= mlim)); // R17 R18
   end

   // ==========================================================
   // next state
   always_comb begin
      logic req;
      logic [7:0] a;
      logic start;
      logic abort;
      logic [31:0] wd;
      logic [3:0] be;
      req = AVS_READ_I | AVS_WRITE_I;
      a = AVS_ADDRESS_I;
      wd = AVS_WRITEDATA_I;
      be = AVS_BYTEENABLE_I;
      start = 1'b0;
      abort = 1'b0;
      next_s = s;
      // bus: answer one cycle after the request is seen
      next_s.ack = req & ~s.ack;
      next_s.wreq = ~next_s.ack;
      if (AVS_READ_I & ~s.ack) begin
         case (a)
            genset_cc_pkg::OFS_CTRL: next_s.rdata = s.ctrl;
            genset_cc_pkg::OFS_CUT_V: next_s.rdata = s.cut_v;
            genset_cc_pkg::OFS_CUT_HZ: next_s.rdata = s.cut_hz;
            genset_cc_pkg::OFS_CUT_RPM: next_s.rdata = s.cut_rpm;
            genset_cc_pkg::OFS_CUT_CHG: next_s.rdata = s.cut_chg;
            genset_cc_pkg::OFS_TIMES: next_s.rdata = s.times;
            genset_cc_pkg::OFS_COOL: next_s.rdata = s.cool;
            genset_cc_pkg::OFS_FUEL: next_s.rdata = s.fuel;
            genset_cc_pkg::OFS_SVC0: next_s.rdata = s.svc[0];
            genset_cc_pkg::OFS_SVC0 + 8'h04: next_s.rdata = s.svc[1];
            genset_cc_pkg::OFS_SVC0 + 8'h08: next_s.rdata = s.svc[2];
            genset_cc_pkg::OFS_STATUS: begin
               next_s.rdata = {21'h0, s.st, s.fail, s.stop, s.req, s.heater, s.cooler,
                               s.gas, s.crank};
            end
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (AVS_WRITE_I & s.ack) begin
         case (a)
            genset_cc_pkg::OFS_CTRL: next_s.ctrl = merge(s.ctrl, wd, be);
            genset_cc_pkg::OFS_CMD: begin
               start = be[0] & wd[genset_cc_pkg::CMD_START];
               abort = be[0] & wd[genset_cc_pkg::CMD_ABORT];
            end
            genset_cc_pkg::OFS_CUT_V: next_s.cut_v = merge(s.cut_v, wd, be);
            genset_cc_pkg::OFS_CUT_HZ: next_s.cut_hz = merge(s.cut_hz, wd, be);
            genset_cc_pkg::OFS_CUT_RPM: next_s.cut_rpm = merge(s.cut_rpm, wd, be);
            genset_cc_pkg::OFS_CUT_CHG: next_s.cut_chg = merge(s.cut_chg, wd, be);
            genset_cc_pkg::OFS_TIMES: next_s.times = merge(s.times, wd, be);
            genset_cc_pkg::OFS_COOL: next_s.cool = merge(s.cool, wd, be);
            genset_cc_pkg::OFS_FUEL: next_s.fuel = merge(s.fuel, wd, be);
            genset_cc_pkg::OFS_SVC0: next_s.svc[0] = merge(s.svc[0], wd, be);
            genset_cc_pkg::OFS_SVC0 + 8'h04: next_s.svc[1] = merge(s.svc[1], wd, be);
            genset_cc_pkg::OFS_SVC0 + 8'h08: next_s.svc[2] = merge(s.svc[2], wd, be);
            default: ;
         endcase
      end

      // crank attempt
      next_s.stop = ecu_en & ECU_LOST_I; // R22
      if (tick && s.crank_sec != 8'hFF) begin
         next_s.crank_sec = s.crank_sec + 8'h01; // R25
      end
      case (s.st)
         C_IDLE, C_RUN, C_FAIL: begin
            if (start & ~next_s.stop) begin
               next_s.st = C_CRANK;
               next_s.crank_sec = 8'h00;
               next_s.fail = 1'b0;
            end
         end
         C_CRANK: begin
            if (abort | next_s.stop) begin
               next_s.st = C_IDLE;
            end else if (cut_any) begin
               next_s.st = C_RUN; // R02 R03 R04 R05 R24
            end else if (s.crank_sec >= s.times[genset_cc_pkg::TM_CRANK +: 8]) begin
               next_s.st = C_FAIL; // R23
               next_s.fail = 1'b1;
            end
         end
         default: next_s.st = C_IDLE;
      endcase
      next_s.crank = (next_s.st == C_CRANK);
      next_s.gas = next_s.crank & s.ctrl[genset_cc_pkg::CTRL_GAS_ASG] &
                   (s.crank_sec >= s.times[genset_cc_pkg::TM_GAS +: 8]); // R01

      // oil condition must stand unbroken for the whole delay
      if (!oil_cond || s.st != C_CRANK) begin
         next_s.oil_sec = 8'h00;
      end else if (tick && s.oil_sec != 8'hFF) begin
         next_s.oil_sec = s.oil_sec + 8'h01; // R08 R25
      end

      // cooler with hysteresis and fan overrun
      if (temp > s.cool[genset_cc_pkg::CL_COOL_ON +: 8]) begin
         next_s.cooler = 1'b1; // R11
         next_s.fan_sec = 8'h00;
      end else if (s.cooler && temp < s.cool[genset_cc_pkg::CL_COOL_OFF +: 8]) begin
         if (s.fan_sec >= s.times[genset_cc_pkg::TM_FAN +: 8]) begin
            next_s.cooler = 1'b0; // R12 R15
         end else if (tick) begin
            next_s.fan_sec = s.fan_sec + 8'h01; // R15 R25
         end
      end else begin
         next_s.fan_sec = 8'h00;
      end
      if (temp < s.cool[genset_cc_pkg::CL_HEAT_ON +: 8]) begin
         next_s.heater = 1'b1; // R13
      end else if (temp > s.cool[genset_cc_pkg::CL_HEAT_OFF +: 8]) begin
         next_s.heater = 1'b0; // R14
      end

      // fuel, service and engine link
      next_s.fuel_show = s.fuel[genset_cc_pkg::FU_CAP +: 16] != 16'h0000; // R09
      next_s.theft = (s.fuel[genset_cc_pkg::FU_PCT +: 8] != 8'h00) &
                     (FUEL_DROP_PCT_I > s.fuel[genset_cc_pkg::FU_PCT +: 8]); // R10
      next_s.fuelling = (s.fuel[genset_cc_pkg::FU_PCT +: 8] != 8'h00) &
                        (FUEL_RISE_PCT_I > s.fuel[genset_cc_pkg::FU_PCT +: 8]); // R10
      next_s.req = req_now;
      next_s.led = |req_now; // R16 R17
      next_s.shut = lvl_is(req_now, s.svc, genset_cc_pkg::LVL_SHUT); // R19
      next_s.dump = lvl_is(req_now, s.svc, genset_cc_pkg::LVL_DUMP); // R19
      next_s.warn = lvl_is(req_now, s.svc, genset_cc_pkg::LVL_WARN); // R19
      next_s.ecu_port = ecu_en; // R20
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         s <= '0;
         s.ctrl <= genset_cc_pkg::RST_CTRL;
         s.cut_v <= genset_cc_pkg::RST_CUT_V;
         s.cut_hz <= genset_cc_pkg::RST_CUT_HZ;
         s.cut_rpm <= genset_cc_pkg::RST_CUT_RPM;
         s.cut_chg <= genset_cc_pkg::RST_CUT_CHG;
         s.times <= genset_cc_pkg::RST_TIMES;
         s.cool <= genset_cc_pkg::RST_COOL;
         s.fuel <= genset_cc_pkg::RST_FUEL;
         s.svc[0] <= genset_cc_pkg::RST_SVC0;
         s.svc[1] <= genset_cc_pkg::RST_SVC12;
         s.svc[2] <= genset_cc_pkg::RST_SVC12;
         s.wreq <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs
   assign AVS_READDATA_O = s.rdata;
   assign AVS_WAITREQUEST_O = s.wreq;
   assign CRANK_O = s.crank;
   assign GAS_SOL_O = s.gas;
   assign COOLER_O = s.cooler;
   assign HEATER_O = s.heater;
   assign SVC_LED_O = s.led;
   assign SHUTDOWN_O = s.shut;
   assign LOADDUMP_O = s.dump;
   assign WARNING_O = s.warn;
   assign FUEL_SHOW_O = s.fuel_show;
   assign THEFT_MSG_O = s.theft;
   assign FUELLING_MSG_O = s.fuelling;
   assign ECU_PORT_EN_O = s.ecu_port;
   assign ENG_STOP_O = s.stop;
   assign CRANK_FAIL_O = s.fail;

   // ==========================================================
   // assertions
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RESETN_I);

   // abort strobe in the cycle the command register takes it
   logic abort_seen;
   assign abort_seen = AVS_WRITE_I & s.ack & (AVS_ADDRESS_I == genset_cc_pkg::OFS_CMD) &
                       AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[genset_cc_pkg::CMD_ABORT];

   sequence s_cranking;
      s.st == C_CRANK && !ECU_LOST_I;
   endsequence

   AST_GAS_WAIT: assert property ((s.st == C_CRANK && s.crank_sec < s.times[7:0]) |=> !GAS_SOL_O) // R01
      else $error("gas solenoid opened before its delay");
   AST_CUT_VOLT: assert property ((s_cranking and GEN_VOLT_I >= s.cut_v[15:0]) |=> !CRANK_O) // R02
      else $error("crank held after voltage cut");
   AST_CUT_FREQ: assert property ((s_cranking and GEN_FREQ_I >= s.cut_hz[7:0]) |=> !CRANK_O) // R03
      else $error("crank held after frequency cut");
   AST_CUT_RPM: assert property ((s_cranking and rpm >= s.cut_rpm[15:0]) |=> !CRANK_O) // R04
      else $error("crank held after speed cut");
   AST_CUT_CHG: assert property ((s.st == C_CRANK && !s.ctrl[0] && CHG_VOLT_I >= s.cut_chg[7:0]
      && !cut_volt && !cut_freq && !cut_spd && !cut_oil && !abort_seen
      && !(ecu_en && ECU_LOST_I) && s.crank_sec < s.times[23:16]) |=> CRANK_O) // R06
      else $error("charge cut acted while disabled");
   AST_COOL_ON: assert property ((temp > s.cool[7:0]) |=> COOLER_O) // R11
      else $error("cooler not on above limit");
   AST_HEAT_ON: assert property ((temp < s.cool[23:16]) |=> HEATER_O) // R13
      else $error("heater not on below limit");
   AST_LINK_OFF: assert property ((!ecu_en) [*2] |-> !ECU_PORT_EN_O) // R20
      else $error("link port active while disabled");
   AST_ECU_STOP: assert property ((ecu_en && ECU_LOST_I) |=> ENG_STOP_O && !CRANK_O) // R22
      else $error("engine not stopped on ECU loss");

endmodule
`default_nettype wire

// File: src/genset_cc_pkg.sv
// constants for the crank-cut, coolant and service controller
package genset_cc_pkg;
   // ==========================================================
   // timing
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned TICK_S = 1;
   localparam int unsigned TICK_CYC = TICK_S * CLK_HZ;
   // ==========================================================
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMD = 8'h04;
   localparam logic [7:0] OFS_CUT_V = 8'h08;
   localparam logic [7:0] OFS_CUT_HZ = 8'h0C;
   localparam logic [7:0] OFS_CUT_RPM = 8'h10;
   localparam logic [7:0] OFS_CUT_CHG = 8'h14;
   localparam logic [7:0] OFS_TIMES = 8'h18;
   localparam logic [7:0] OFS_COOL = 8'h1C;
   localparam logic [7:0] OFS_FUEL = 8'h20;
   localparam logic [7:0] OFS_SVC0 = 8'h24;
   localparam logic [7:0] OFS_STATUS = 8'h30;
   // ==========================================================
   // field positions
   localparam int CTRL_CHG_EN = 0;
   localparam int CTRL_OIL_EN = 1;
   localparam int CTRL_ECU_EN = 2;
   localparam int CTRL_GAS_ASG = 3;
   localparam int CTRL_OIL_LIM = 8;
   localparam int CMD_START = 0;
   localparam int CMD_ABORT = 1;
   localparam int TM_GAS = 0;
   localparam int TM_OIL = 8;
   localparam int TM_CRANK = 16;
   localparam int TM_FAN = 24;
   localparam int CL_COOL_ON = 0;
   localparam int CL_COOL_OFF = 8;
   localparam int CL_HEAT_ON = 16;
   localparam int CL_HEAT_OFF = 24;
   localparam int FU_CAP = 0;
   localparam int FU_PCT = 16;
   localparam int SV_HOURS = 0;
   localparam int SV_MONTHS = 16;
   localparam int SV_LEVEL = 24;
   // ==========================================================
   // reset values
   localparam logic [31:0] RST_CTRL = 32'h0000_0A00;
   localparam logic [31:0] RST_CUT_V = 32'h0000_0064;
   localparam logic [31:0] RST_CUT_HZ = 32'h0000_000A;
   localparam logic [31:0] RST_CUT_RPM = 32'h0000_01F4;
   localparam logic [31:0] RST_CUT_CHG = 32'h0000_0006;
   localparam logic [31:0] RST_TIMES = 32'h0006_0205;
   localparam logic [31:0] RST_COOL = 32'h3C32_505A;
   localparam logic [31:0] RST_FUEL = 32'h0000_0000;
   localparam logic [31:0] RST_SVC0 = 32'h0306_00FA;
   localparam logic [31:0] RST_SVC12 = 32'h0006_00FA;
   // alarm levels
   localparam logic [1:0] LVL_NONE = 2'h0;
   localparam logic [1:0] LVL_SHUT = 2'h1;
   localparam logic [1:0] LVL_DUMP = 2'h2;
   localparam logic [1:0] LVL_WARN = 2'h3;
endpackage

// File: src/sec_tick.sv
// one-cycle seconds tick divided down from the system clock
`timescale 1ns/10ps
`default_nettype none
module sec_tick #(
   parameter int unsigned CYCLES = 100
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // tick
   output logic tick_o
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);
   logic [W-1:0] cnt;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= '0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= (cnt == LAST);
         cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
      end
   end
endmodule
`default_nettype wire

// File: testbench/genset_eng_model.sv
// engine and alternator sensor model that fires one chosen cut condition
`timescale 1ns/10ps
`default_nettype none
module genset_eng_model (
   // clock, reset and crank relay
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic crank_i,
   // which measurement reaches its cut level once fired, 0 = engine stopped
   input wire logic [2:0] sel_i,
   // sensors
   output logic [15:0] volt_o,
   output logic [7:0] freq_o,
   output logic [7:0] chg_o,
   output logic [15:0] rpm_o,
   output logic [7:0] oil_o,
   output logic sw_open_o
);
   // ==========================================================
   // firing
   logic [2:0] cnt;
   logic fired;
   // fires after five crank cycles; voltage, frequency, speed and charge idle one below their cut defaults
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt <= 3'h0;
         fired <= 1'b0;
      end else if (sel_i == 3'h0) begin
         cnt <= 3'h0;
         fired <= 1'b0;
      end else if (crank_i && !fired) begin
         cnt <= cnt + 3'h1;
         fired <= cnt == 3'h4;
      end
   end
   assign volt_o = 16'h0063 + 16'(fired && sel_i == 3'h1);
   assign freq_o = 8'h09 + 8'(fired && sel_i == 3'h2);
   assign rpm_o = 16'h01F3 + 16'(fired && sel_i == 3'h3);
   assign chg_o = 8'h05 + 8'(fired && sel_i == 3'h4);
   assign oil_o = 8'h00;
   assign sw_open_o = fired && sel_i == 3'h5;
endmodule
`default_nettype wire

// File: testbench/tb_genset_cc.sv
// self-checking bench for the crank-cut, coolant, fuel and service controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
`define WT(c, n) begin wk = 0; while (!(c) && wk < n) begin @(negedge MCLK_I); wk++; end \
   if (!(c)) begin error_cnt++; $display("[FAIL] wait exp 1 got 0"); tally_and_finish; end end
module tb_genset_cc;
   logic MCLK_I, RESETN_I, AVS_READ_I, AVS_WRITE_I, OIL_SW_OPEN_I, ECU_LOST_I;
   logic [7:0] AVS_ADDRESS_I, GEN_FREQ_I, CHG_VOLT_I, COOLANT_I, OIL_PRES_I;
   logic [7:0] ECU_COOLANT_I, ECU_OIL_PRES_I, FUEL_DROP_PCT_I, FUEL_RISE_PCT_I;
   logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O;
   logic [3:0] AVS_BYTEENABLE_I;
   logic [15:0] GEN_VOLT_I, RPM_I, ECU_RPM_I;
   logic [2:0][15:0] SVC_HOURS_I;
   logic [2:0][7:0] SVC_MONTHS_I;
   logic AVS_WAITREQUEST_O, CRANK_O, GAS_SOL_O, COOLER_O, HEATER_O, SVC_LED_O, SHUTDOWN_O;
   logic LOADDUMP_O, WARNING_O, FUEL_SHOW_O, THEFT_MSG_O, FUELLING_MSG_O, ECU_PORT_EN_O;
   logic ENG_STOP_O, CRANK_FAIL_O;
   logic [2:0] sel;
   int error_cnt, tests_run, wk;
   // one second is ten clocks here
   genset_cc #(.TICK_CYCLES(10)) i_dut (.*);
   genset_eng_model i_eng (.clk_i(MCLK_I), .rstn_i(RESETN_I), .crank_i(CRANK_O), .sel_i(sel),
      .volt_o(GEN_VOLT_I), .freq_o(GEN_FREQ_I), .chg_o(CHG_VOLT_I), .rpm_o(RPM_I),
      .oil_o(OIL_PRES_I), .sw_open_o(OIL_SW_OPEN_I));
   always #5 MCLK_I = ~MCLK_I;
   // ==========================================================
   // common tasks
   task automatic tally_and_finish;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      @(posedge MCLK_I);
      AVS_ADDRESS_I <= a;
      AVS_WRITE_I <= w;
      AVS_READ_I <= !w;
      AVS_WRITEDATA_I <= d;
      do begin
         @(negedge MCLK_I);
         n++;
      end while (AVS_WAITREQUEST_O !== 1'b0 && n < 50);
      `WT(n < 50, 1)
      @(posedge MCLK_I);
      q = AVS_READDATA_O;
      AVS_WRITE_I <= 1'b0;
      AVS_READ_I <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      `CHK("reg", e, q)
   endtask
   task automatic settle;
      repeat (3) @(posedge MCLK_I);
      @(negedge MCLK_I);
   endtask
   task automatic start(input logic [2:0] s);
      @(posedge MCLK_I);
      sel <= s;
      wr(genset_cc_pkg::OFS_CMD, 32'h0000_0001);
      `WT(CRANK_O === 1'b1, 10)
   endtask
   task automatic stop;
      @(posedge MCLK_I);
      sel <= 3'h0;
      wr(genset_cc_pkg::OFS_CMD, 32'h0000_0002);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset;
      `CHK("port", 1'b0, ECU_PORT_EN_O)
      rdc(genset_cc_pkg::OFS_CTRL, 32'h0000_0A00);
      rdc(genset_cc_pkg::OFS_CUT_V, 32'h0000_0064);
      rdc(genset_cc_pkg::OFS_CUT_HZ, 32'h0000_000A);
      rdc(genset_cc_pkg::OFS_CUT_RPM, 32'h0000_01F4);
      rdc(genset_cc_pkg::OFS_CUT_CHG, 32'h0000_0006);
      rdc(genset_cc_pkg::OFS_TIMES, 32'h0006_0205);
      rdc(genset_cc_pkg::OFS_COOL, 32'h3C32_505A);
      rdc(genset_cc_pkg::OFS_SVC0, 32'h0306_00FA);
      rdc(8'h28, 32'h0006_00FA);
      rdc(8'h40, 32'h0000_0000);
   endtask
   task automatic t_cut(input logic [2:0] s);
      start(s);
      `WT(CRANK_O === 1'b0, 40)
      `CHK("cut_time", 1'b1, wk >= 4 && wk < 12)
      `CHK("fail", 1'b0, CRANK_FAIL_O)
      stop;
   endtask
   task automatic t_chg;
      wr(genset_cc_pkg::OFS_CTRL, 32'h0000_0A08);
      start(3'h4);
      `CHK("gas_early", 1'b0, GAS_SOL_O)
      `WT(GAS_SOL_O === 1'b1, 40)
      `CHK("gas_time", 1'b1, wk >= 8)
      `WT(CRANK_O === 1'b0, 80)
      `CHK("crank_time", 1'b1, wk >= 25)
      `CHK("fail", 1'b1, CRANK_FAIL_O)
      stop;
   endtask
   task automatic t_oil;
      wr(genset_cc_pkg::OFS_CTRL, 32'h0000_0A02);
      start(3'h5);
      `WT(CRANK_O === 1'b0, 60)
      `CHK("oil_delay", 1'b1, wk >= 14)
      `CHK("fail", 1'b0, CRANK_FAIL_O)
      stop;
   endtask
   task automatic t_ecu;
      wr(genset_cc_pkg::OFS_CTRL, 32'h0000_0A04);
      ECU_RPM_I <= 16'h01F4;
      settle;
      `CHK("port", 1'b1, ECU_PORT_EN_O)
      start(3'h0);
      `WT(CRANK_O === 1'b0, 5)
      @(posedge MCLK_I);
      ECU_LOST_I <= 1'b1;
      `WT(ENG_STOP_O === 1'b1, 5)
      @(posedge MCLK_I);
      ECU_LOST_I <= 1'b0;
      ECU_RPM_I <= 16'h0000;
      wr(genset_cc_pkg::OFS_CTRL, 32'h0000_0A00);
      stop;
   endtask
   task automatic cool(input logic [7:0] v);
      @(posedge MCLK_I);
      COOLANT_I <= v;
      settle;
   endtask
   task automatic t_cool;
      cool(8'h5A);
      `CHK("cooler", 1'b0, COOLER_O)
      cool(8'h5B);
      `CHK("cooler", 1'b1, COOLER_O)
      cool(8'h55);
      `CHK("cooler", 1'b1, COOLER_O)
      cool(8'h4F);
      `CHK("cooler", 1'b1, COOLER_O)
      `WT(COOLER_O === 1'b0, 50)
      `CHK("overrun", 1'b1, wk >= 12)
      cool(8'h31);
      `CHK("heater", 1'b1, HEATER_O)
      cool(8'h3C);
      `CHK("heater", 1'b1, HEATER_O)
      cool(8'h3D);
      `CHK("heater", 1'b0, HEATER_O)
   endtask
   task automatic t_fuel;
      @(posedge MCLK_I);
      FUEL_DROP_PCT_I <= 8'h06;
      FUEL_RISE_PCT_I <= 8'h06;
      settle;
      `CHK("show", 1'b0, FUEL_SHOW_O)
      `CHK("theft", 1'b0, THEFT_MSG_O | FUELLING_MSG_O)
      wr(genset_cc_pkg::OFS_FUEL, 32'h0005_0064);
      settle;
      `CHK("show", 1'b1, FUEL_SHOW_O)
      `CHK("msgs", 1'b1, THEFT_MSG_O & FUELLING_MSG_O)
      @(posedge MCLK_I);
      FUEL_DROP_PCT_I <= 8'h05;
      settle;
      `CHK("theft", 1'b0, THEFT_MSG_O)
   endtask
   task automatic t_svc;
      `CHK("led", 1'b0, SVC_LED_O)
      @(posedge MCLK_I);
      SVC_HOURS_I[0] <= 16'h00FA;
      settle;
      `CHK("led", 1'b1, SVC_LED_O)
      `CHK("warn", 1'b1, WARNING_O)
      for (int l = 0; l < 3; l++) begin
         wr(genset_cc_pkg::OFS_SVC0, {6'h00, 2'(l), 24'h06_00FA});
         settle;
         `CHK("shut", l == 1, SHUTDOWN_O)
         `CHK("dump", l == 2, LOADDUMP_O)
         `CHK("warn", 1'b0, WARNING_O)
      end
      wr(genset_cc_pkg::OFS_SVC0, 32'h0006_0000);
      settle;
      `CHK("led", 1'b0, SVC_LED_O)
      @(posedge MCLK_I);
      SVC_MONTHS_I[1] <= 8'h06;
      settle;
      `CHK("led", 1'b1, SVC_LED_O)
      wr(8'h28, 32'h0000_00FA);
      settle;
      `CHK("led", 1'b0, SVC_LED_O)
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {MCLK_I, RESETN_I, AVS_READ_I, AVS_WRITE_I, ECU_LOST_I, sel} = '0;
      {AVS_ADDRESS_I, AVS_WRITEDATA_I, ECU_RPM_I, ECU_COOLANT_I, ECU_OIL_PRES_I} = '0;
      {FUEL_DROP_PCT_I, FUEL_RISE_PCT_I, SVC_MONTHS_I} = '0;
      AVS_BYTEENABLE_I = 4'hF;
      COOLANT_I = 8'h46;
      SVC_HOURS_I = {3{16'h00F9}};
      error_cnt = 0;
      tests_run = 0;
      repeat (8) @(posedge MCLK_I);
      RESETN_I <= 1'b1;
      t_reset;
      wr(genset_cc_pkg::OFS_TIMES, 32'h0306_0202);
      wr(genset_cc_pkg::OFS_CTRL, 32'h0000_0A01);
      for (int s = 1; s < 5; s++) t_cut(3'(s));
      t_chg;
      t_oil;
      t_ecu;
      t_cool;
      t_fuel;
      t_svc;
      tally_and_finish;
   end
endmodule
`default_nettype wire
